// >>> rtl/ppu_datapath.sv
`timescale 1ns/1ps
`include "ppu_defs.svh"
// Operation
// RULE_01 - 64-bit dword pack clamps to signed words
// RULE_02 - 128-bit form packs eight saturated words
// RULE_03 - word pack gives eight unsigned bytes; the 128-bit form gives sixteen
// RULE_04 - pack inputs always read as signed
// RULE_05 - unpack interleaves dst and src elements
// RULE_06 - low word unpack self fills upper halves
// RULE_07 - high word unpack self fills upper halves
// RULE_08 - arithmetic right shift replicates lane sign
// RULE_09 - low dword unpack appends src low dword
// RULE_10 - high dword unpack moves dst high down
// RULE_11 - logical left shift fills zeros
// RULE_12 - AND combines operands bitwise
// RULE_13 - OR merges operands bitwise
// RULE_14 - extract selects word by imm[1:0]
// RULE_15 - extract zero-extends into gpr
// RULE_16 - pack then unpack interleaves two operands
// RULE_17 - saturation limits exact at range ends
// RULE_18 - fixed latency, valid cleared by reset
module ppu_datapath (
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire ppu_pkg::ppu_req_s i_req,
    output ppu_pkg::ppu_rsp_s      o_rsp
);
    import ppu_pkg::*;

    ppu_state_s s_q;
    ppu_state_s s_d;
    logic       rst_n_sync;
    ppu_rsp_s   res;

    // *************************************************************
    // saturation helpers
    // *************************************************************
    function automatic logic [15:0] sat_s16(input logic [31:0] v);
        logic signed [31:0] sv;
        sv = $signed(v); // RULE_04
        if (sv > `PPU_SMAX16)
            sat_s16 = `PPU_W16_MAX; // RULE_17
        else if (sv < `PPU_SMIN16)
            sat_s16 = `PPU_W16_MIN; // RULE_17
        else
            sat_s16 = v[15:0];
    endfunction

    function automatic logic [7:0] sat_u8(input logic [15:0] v);
        logic signed [15:0] sv;
        sv = $signed(v); // RULE_04
        if (sv < `PPU_S16_ZERO)
            sat_u8 = `PPU_B8_MIN; // RULE_17
        else if (sv > `PPU_UMAX8)
            sat_u8 = `PPU_B8_MAX; // RULE_17
        else
            sat_u8 = v[7:0];
    endfunction

    // *************************************************************
    // reset release
    // *************************************************************
    assign rst_n_sync = s_q.rst2;

    // *************************************************************
    // operand views
    // *************************************************************
    logic [63:0]  dl;
    logic [63:0]  sl;
    logic [5:0]   sll_cnt;
    logic [4:0]   sra_cnt;
    logic [1:0]   ext_sel;
    logic [127:0] pack_dw_v;
    logic [127:0] pack_ub_v;
    logic [127:0] unpk_lw_v;
    logic [127:0] unpk_hw_v;
    logic [127:0] unpk_ld_v;
    logic [127:0] unpk_hd_v;
    logic [127:0] sra_v;
    logic [127:0] sll_v;
    logic [127:0] and_v;
    logic [127:0] or_v;
    logic [31:0]  ext_v;

    // 64-bit form reads the low half only
    assign dl      = i_req.dst[63:0];
    assign sl      = i_req.src[63:0];
    assign ext_sel = i_req.imm[`PPU_EXT_SEL_LSB +: 2];

    // *************************************************************
    // shift counts
    // *************************************************************
    // counts past 31 saturate instead of wrapping into the lane
    always_comb
    begin
        if (i_req.imm > `PPU_SHIFT_LIM)
        begin
            sll_cnt = `PPU_SHIFT_ALL;
            sra_cnt = `PPU_SRA_MAX;
        end
        else
        begin
            sll_cnt = i_req.imm[5:0];
            sra_cnt = i_req.imm[4:0];
        end
    end

    // *************************************************************
    // signed dword pack
    // *************************************************************
    // dst lanes fill the low words, src lanes the high words
    always_comb
    begin
        pack_dw_v = '0;
        if (i_req.wide)
        begin
            for (int i = 0; i < 4; i++)
            begin
                pack_dw_v[16*i +: 16] =
                    sat_s16(i_req.dst[32*i +: 32]); // RULE_02
                pack_dw_v[64 + 16*i +: 16] =
                    sat_s16(i_req.src[32*i +: 32]); // RULE_02
            end
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                pack_dw_v[16*i +: 16] =
                    sat_s16(dl[32*i +: 32]); // RULE_01
                pack_dw_v[32 + 16*i +: 16] =
                    sat_s16(sl[32*i +: 32]); // RULE_01
            end
        end
    end

    // *************************************************************
    // word to unsigned byte pack
    // *************************************************************
    always_comb
    begin
        pack_ub_v = '0;
        if (i_req.wide)
        begin
            for (int i = 0; i < 8; i++)
            begin
                pack_ub_v[8*i +: 8] =
                    sat_u8(i_req.dst[16*i +: 16]); // RULE_03
                pack_ub_v[64 + 8*i +: 8] =
                    sat_u8(i_req.src[16*i +: 16]); // RULE_03
            end
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                pack_ub_v[8*i +: 8] =
                    sat_u8(dl[16*i +: 16]); // RULE_03
                pack_ub_v[32 + 8*i +: 8] =
                    sat_u8(sl[16*i +: 16]); // RULE_03
            end
        end
    end

    // *************************************************************
    // word unpack
    // *************************************************************
    // dst word low, src word high; same reg doubles each word
    always_comb
    begin
        unpk_lw_v = '0;
        unpk_hw_v = '0;
        for (int i = 0; i < 4; i++)
        begin
            if (i_req.wide)
            begin
                unpk_lw_v[32*i +: 16]      = i_req.dst[16*i +: 16];
                unpk_lw_v[32*i + 16 +: 16] = i_req.src[16*i +: 16];
                unpk_hw_v[32*i +: 16]      = i_req.dst[64 + 16*i +: 16];
                unpk_hw_v[32*i + 16 +: 16] = i_req.src[64 + 16*i +: 16];
            end
            else if (i < 2)
            begin
                unpk_lw_v[32*i +: 16] = dl[16*i +: 16]; // RULE_05
                unpk_lw_v[32*i + 16 +: 16] =
                    sl[16*i +: 16]; // RULE_06 RULE_16
                unpk_hw_v[32*i +: 16] = dl[32 + 16*i +: 16]; // RULE_05
                unpk_hw_v[32*i + 16 +: 16] =
                    sl[32 + 16*i +: 16]; // RULE_07
            end
        end
    end

    // *************************************************************
    // dword unpack
    // *************************************************************
    always_comb
    begin
        unpk_ld_v = '0;
        unpk_hd_v = '0;
        if (i_req.wide)
        begin
            unpk_ld_v = {i_req.src[63:32], i_req.dst[63:32],
                         i_req.src[31:0], i_req.dst[31:0]};
            unpk_hd_v = {i_req.src[127:96], i_req.dst[127:96],
                         i_req.src[95:64], i_req.dst[95:64]};
        end
        else
        begin
            unpk_ld_v[63:0] = {sl[31:0], dl[31:0]}; // RULE_09
            unpk_hd_v[63:0] = {sl[63:32], dl[63:32]}; // RULE_10
        end
    end

    // *************************************************************
    // per-lane shifts
    // *************************************************************
    always_comb
    begin
        sra_v = '0;
        sll_v = '0;
        for (int i = 0; i < 4; i++)
        begin
            if (i_req.wide || i < 2)
            begin
                sra_v[32*i +: 32] = 32'($signed(
                    i_req.dst[32*i +: 32]) >>> sra_cnt); // RULE_08
                sll_v[32*i +: 32] =
                    i_req.dst[32*i +: 32] << sll_cnt; // RULE_11
            end
        end
    end

    // *************************************************************
    // bitwise
    // *************************************************************
    // 64-bit form leaves the high half of the result clear
    always_comb
    begin
        and_v = i_req.dst & i_req.src; // RULE_12
        or_v  = i_req.dst | i_req.src; // RULE_13
        if (!i_req.wide)
        begin
            and_v[127:64] = '0;
            or_v[127:64]  = '0;
        end
    end

    // *************************************************************
    // word extract
    // *************************************************************
    // only the low 64 bits feed the selector, whatever the form
    assign ext_v = {`PPU_EXT_PAD, sl[16*ext_sel +: 16]}; // RULE_14 RULE_15

    // *************************************************************
    // result select
    // *************************************************************
    always_comb
    begin
        res       = '0;
        res.valid = i_req.valid;
        case (i_req.op)
            PPU_OP_PACK_DW_SAT:
            begin
                res.vec = pack_dw_v;
            end
            PPU_OP_PACK_W_UBYTE:
            begin
                res.vec = pack_ub_v;
            end
            PPU_OP_UNPACK_LO_W:
            begin
                res.vec = unpk_lw_v;
            end
            PPU_OP_UNPACK_HI_W:
            begin
                res.vec = unpk_hw_v;
            end
            PPU_OP_UNPACK_LO_DW:
            begin
                res.vec = unpk_ld_v;
            end
            PPU_OP_UNPACK_HI_DW:
            begin
                res.vec = unpk_hd_v;
            end
            PPU_OP_SHIFT_RA_DW:
            begin
                res.vec = sra_v;
            end
            PPU_OP_SHIFT_LL_DW:
            begin
                res.vec = sll_v;
            end
            PPU_OP_AND:
            begin
                res.vec = and_v;
            end
            PPU_OP_OR:
            begin
                res.vec = or_v;
            end
            PPU_OP_EXTRACT_W:
            begin
                res.to_gpr = 1'b1;
                res.gpr    = ext_v;
            end
            // undefined codes are refused; nothing reaches the core
            default:
            begin
                res.valid = 1'b0;
            end
        endcase
    end

    // *************************************************************
    // pipeline state
    // *************************************************************
    always_comb
    begin
        s_d         = s_q;
        s_d.rst1    = 1'b1;
        s_d.rst2    = s_q.rst1;
        s_d.stage_q = res;        // RULE_18
        s_d.out_q   = s_q.stage_q; // RULE_18
        if (!rst_n_sync)
        begin
            s_d.stage_q.valid = 1'b0; // RULE_18
            s_d.out_q.valid   = 1'b0; // RULE_18
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign o_rsp = s_q.out_q;
endmodule

// >>> rtl/ppu_defs.svh
`ifndef PPU_DEFS_SVH
`define PPU_DEFS_SVH
// *************************************************************
// constants
// *************************************************************
`define PPU_LATENCY     2'h2
`define PPU_SMAX16      32'sh00007fff
`define PPU_SMIN16      -32'sh00008000
`define PPU_UMAX8       16'sh00ff
`define PPU_W16_MAX     16'h7fff
`define PPU_W16_MIN     16'h8000
`define PPU_B8_MAX      8'hff
`define PPU_B8_MIN      8'h00
`define PPU_SHIFT_MAX   6'h1f
`define PPU_EXT_SEL_LSB 0
`define PPU_SHIFT_LIM   8'h1f
`define PPU_SHIFT_ALL   6'h20
`define PPU_SRA_MAX     5'h1f
`define PPU_EXT_PAD     16'h0000
`define PPU_S16_ZERO    16'sh0000
`endif

// >>> rtl/ppu_pkg.sv
package ppu_pkg;
    typedef enum logic [3:0] {
        PPU_OP_PACK_DW_SAT,
        PPU_OP_PACK_W_UBYTE,
        PPU_OP_UNPACK_LO_W,
        PPU_OP_UNPACK_HI_W,
        PPU_OP_UNPACK_LO_DW,
        PPU_OP_UNPACK_HI_DW,
        PPU_OP_SHIFT_RA_DW,
        PPU_OP_SHIFT_LL_DW,
        PPU_OP_AND,
        PPU_OP_OR,
        PPU_OP_EXTRACT_W
    } ppu_op_e;

    typedef struct packed {
        logic         valid;
        ppu_op_e      op;
        logic         wide;
        logic [127:0] dst;
        logic [127:0] src;
        logic [7:0]   imm;
    } ppu_req_s;

    typedef struct packed {
        logic         valid;
        logic         to_gpr;
        logic [127:0] vec;
        logic [31:0]  gpr;
    } ppu_rsp_s;

    typedef struct packed {
        logic     rst1;
        logic     rst2;
        ppu_rsp_s stage_q;
        ppu_rsp_s out_q;
    } ppu_state_s;
endpackage

// >>> verification/ppu_core_model.sv
`timescale 1ns/1ps
// ****
// issue side and result capture
// ****
module ppu_core_model
    import ppu_pkg::*;
(
    input  wire logic              i_clock,
    input  wire ppu_pkg::ppu_rsp_s i_rsp,
    output ppu_pkg::ppu_req_s      o_req
);
    ppu_rsp_s got[$];
    initial o_req = '0;
    always @(posedge i_clock)
        if (i_rsp.valid === 1'b1) got.push_back(i_rsp);
    task send(input ppu_op_e op, input logic w, input logic [127:0] d,
              input logic [127:0] s, input logic [7:0] im);
        @(posedge i_clock);
        o_req <= '{1'b1, op, w, d, s, im};
    endtask
    // stale operands flip so they never pass for live data
    task idle();
        @(posedge i_clock);
        o_req.valid <= 1'b0;
        o_req.dst   <= ~o_req.dst;
        o_req.src   <= ~o_req.src;
    endtask
endmodule

// >>> verification/ppu_datapath_sva.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module ppu_datapath_sva
    import ppu_pkg::*;
(
    input wire logic              i_clock,
    input wire logic              i_rst_n,
    input wire ppu_pkg::ppu_req_s i_req,
    input wire ppu_pkg::ppu_rsp_s o_rsp
);
    logic [2:0]  up_q;
    logic        ok_w;
    logic [63:0] and_w;
    logic [63:0] lo_w;
    logic [15:0] ext_w;
    logic [31:0] sll_w;
    logic [31:0] sra_w;
    // early requests are dropped while the reset sync settles
    always_ff @(posedge i_clock or negedge i_rst_n)
        if (!i_rst_n) up_q <= 3'h0;
        else if (!up_q[2]) up_q <= up_q + 3'h1;
    assign ok_w  = up_q[2] && i_req.valid && i_req.op <= PPU_OP_EXTRACT_W;
    assign and_w = i_req.dst[63:0] & i_req.src[63:0];
    assign lo_w  = {i_req.src[31:0], i_req.dst[31:0]};
    assign ext_w = i_req.src[{i_req.imm[1:0], 4'h0} +: 16];
    assign sll_w = i_req.imm > 8'h1f ? 32'h0 : i_req.dst[31:0] << i_req.imm;
    assign sra_w = 32'($signed(i_req.dst[31:0]) >>>
                       (i_req.imm > 8'h1f ? 8'h1f : i_req.imm));
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    chk_answer_lat: assert property (
        ok_w |-> ##2 o_rsp.valid) else $error("late result");
    chk_no_stray: assert property (
        up_q[2] && o_rsp.valid |-> $past(i_req.valid, 2))
        else $error("stray result");
    chk_and_bits: assert property (
        ok_w && i_req.op == PPU_OP_AND |->
        ##2 o_rsp.vec[63:0] == $past(and_w, 2)) else $error("and");
    chk_unpack_lo: assert property (
        ok_w && i_req.op == PPU_OP_UNPACK_LO_DW |->
        ##2 o_rsp.vec[63:0] == $past(lo_w, 2)) else $error("unpack lo");
    chk_ext_sel: assert property (
        ok_w && i_req.op == PPU_OP_EXTRACT_W |-> ##2 o_rsp.to_gpr
        && o_rsp.gpr[15:0] == $past(ext_w, 2)) else $error("extract");
    chk_ext_zero: assert property (
        ok_w && i_req.op == PPU_OP_EXTRACT_W |->
        ##2 o_rsp.gpr[31:16] == 16'h0) else $error("extract upper");
    chk_sll_lane: assert property (
        ok_w && i_req.op == PPU_OP_SHIFT_LL_DW |->
        ##2 o_rsp.vec[31:0] == $past(sll_w, 2)) else $error("sll");
    chk_sra_lane: assert property (
        ok_w && i_req.op == PPU_OP_SHIFT_RA_DW |->
        ##2 o_rsp.vec[31:0] == $past(sra_w, 2)) else $error("sra");
    cover property (ok_w && i_req.wide && i_req.op == PPU_OP_PACK_DW_SAT);
    cover property (ok_w && i_req.op == PPU_OP_EXTRACT_W);
    cover property (o_rsp.valid [*3]);
endmodule
bind ppu_datapath ppu_datapath_sva chk (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_req(i_req), .o_rsp(o_rsp));

// >>> verification/ppu_datapath_tb_top.sv
`timescale 1ns/1ps
module ppu_datapath_tb_top;
    import ppu_pkg::*;
    logic     i_clock;
    logic     i_rst_n;
    ppu_req_s req;
    ppu_rsp_s rsp;
    int       n_fail;
    int       cmp_count;
    int       cyc;
    ppu_datapath uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(req),
        .o_rsp(rsp));
    ppu_core_model core (.i_clock(i_clock), .i_rsp(rsp), .o_req(req));
    initial
    begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    // whole run needs under 100 cycles
    always @(posedge i_clock)
        if (++cyc == 2000)
        begin
            n_fail++;
            conclude();
        end
    task conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [127:0] e, input logic [127:0] s);
        cmp_count++;
        if (s !== e)
        begin
            $display("FAIL %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask
    // four edges: two of latency, one to register, one to capture
    task drain();
        core.idle();
        repeat (4) @(posedge i_clock);
    endtask
    task take(input string nm, input logic [127:0] e);
        ppu_rsp_s r;
        r = core.got.size() == 0 ? '0 : core.got.pop_front();
        chk(nm, e, r.to_gpr ? {96'h0, r.gpr} : r.vec);
    endtask
    task t_pack();
        core.send(PPU_OP_PACK_DW_SAT, 1'b0, 128'hfffeee90_00011170,
                  128'hfffffffb_00000005, 8'h00);
        core.send(PPU_OP_PACK_DW_SAT, 1'b1,
                  128'h00007fff_00008000_ffff8000_ffff7fff, '0, 8'h00);
        core.send(PPU_OP_PACK_W_UBYTE, 1'b0, 128'h0100_00ff_ffff_0080,
                  128'h8000_7fff_0001_0000, 8'h00);
        drain();
        take("pack", 128'hfffb_0005_8000_7fff);
        take("pack wide", 128'h7fff_7fff_8000_8000);
        take("pack ubyte", 128'h00ff0100_ffff0080);
    endtask
    task t_unpack();
        core.send(PPU_OP_UNPACK_LO_W, 1'b0, 128'h4, 128'h8_0007_0006_0005,
                  8'h0);
        core.send(PPU_OP_UNPACK_HI_W, 1'b0, 128'h4_0003_0002_0001,
                  128'h8_0007_0006_0005, 8'h0);
        core.send(PPU_OP_UNPACK_LO_DW, 1'b0, 128'h2_00000001, 128'h4_00000003,
                  8'h0);
        core.send(PPU_OP_UNPACK_HI_DW, 1'b0, 128'h2_00000001, 128'h4_00000003,
                  8'h0);
        drain();
        take("unpack lo w", 128'h0006_0000_0005_0004);
        take("unpack hi w", 128'h0008_0004_0007_0003);
        take("unpack lo dw", 128'h3_00000001);
        take("unpack hi dw", 128'h4_00000002);
    endtask
    task t_shift();
        core.send(PPU_OP_UNPACK_LO_W, 1'b0, 128'h80017fff, 128'h80017fff,
                  8'h0);
        core.send(PPU_OP_SHIFT_RA_DW, 1'b0, 128'h80018001_7fff7fff, '0, 8'h10);
        core.send(PPU_OP_SHIFT_LL_DW, 1'b0, 128'h12345678_9abcdef0, '0, 8'h10);
        core.send(PPU_OP_AND, 1'b0, 128'h12345678_9abcdef0,
                  128'h0000ffff_0000ffff, 8'h0);
        core.send(PPU_OP_OR, 1'b0, 128'h5678_0000def0, 128'h12340000_9abc0000,
                  8'h0);
        drain();
        take("unpack self", 128'h8001_8001_7fff_7fff);
        take("sra", 128'hffff8001_00007fff);
        take("sll", 128'h56780000_def00000);
        take("and", 128'h00005678_0000def0);
        take("or", 128'h12345678_9abcdef0);
    endtask
    task t_extract();
        for (int i = 0; i < 4; i++)
            core.send(PPU_OP_EXTRACT_W, 1'b0, '0,
                      {64'hffff_ffff_ffff_ffff, 64'h4444_3333_2222_1111},
                      8'hfc | 8'(i));
        core.send(ppu_op_e'(4'hf), 1'b0, '1, '1, 8'h0);
        drain();
        for (int i = 0; i < 4; i++)
            take("extract", 128'(16'h1111 * 16'(i + 1)));
        chk("refused", 128'h0, 128'(core.got.size()));
    endtask
    task t_wide();
        core.send(PPU_OP_PACK_W_UBYTE, 1'b1, 128'h0100_00ff_ffff_0080,
                  128'h8000_7fff_0001_0000, 8'h0);
        core.send(PPU_OP_UNPACK_HI_DW, 1'b1,
                  128'h4_00000003_00000002_00000001,
                  128'h8_00000007_00000006_00000005, 8'h0);
        drain();
        take("pack ubyte wide", 128'h00ff0100_00000000_ffff0080);
        take("unpack hi dw wide", 128'h8_00000004_00000007_00000003);
    endtask
    task t_chain();
        ppu_rsp_s a;
        ppu_rsp_s b;
        core.send(PPU_OP_PACK_DW_SAT, 1'b0, 128'hffff0000_00012345,
                  128'hffff0000_00012345, 8'h0);
        core.send(PPU_OP_PACK_DW_SAT, 1'b0, 128'h00000003_fffffff0,
                  128'h00000003_fffffff0, 8'h0);
        core.send(PPU_OP_UNPACK_HI_W, 1'b0, 128'h8002_0004_0000_0000,
                  128'h8002_0004_0000_0000, 8'h0);
        drain();
        chk("chain count", 128'h3, 128'(core.got.size()));
        a = core.got.size() > 0 ? core.got.pop_front() : '0;
        b = core.got.size() > 0 ? core.got.pop_front() : '0;
        take("unpack hi self", 128'h8002_8002_0004_0004);
        core.send(PPU_OP_UNPACK_LO_W, 1'b0, a.vec, b.vec, 8'h0);
        drain();
        take("pack unpack", 128'h0003_8000_fff0_7fff);
    endtask
    // reset in mid-flight must drop the pending result
    task t_reset();
        core.send(PPU_OP_AND, 1'b0, '1, '1, 8'h0);
        core.idle();
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        chk("reset flush", 128'h0, 128'(core.got.size()));
        chk("reset out", 128'h0, 128'(rsp.valid));
    endtask
    initial
    begin
        i_rst_n = 1'b0;
        repeat (6) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        t_pack();
        t_unpack();
        t_shift();
        t_extract();
        t_wide();
        t_chain();
        t_reset();
        conclude();
    end
endmodule
